// file: pkg/stats_seq_pkg.sv
// Summary of operation
// - Short line sets error bit 0
// - Pixels beyond active width set error bit 1
// - Early frame start bit 2, late bit 3
// - Input ready low while clearing, then automatic
// - Downstream stall backs up into input ready
// - No output during first two lines
// - Excess pixels dropped until end of line
// - Clear takes 256, 1024 or 4096 cycles
// - Histograms fully cleared before any acquisition
// - Reset order: clear, wait frame, acquire
// - Acquire only on frame start rising edge
// - Measurement frozen while readout is active
// - Memories re-cleared after every readout
// - Held in reset while reset low
// - Hold bit picks readout, else re-clear
// - Done flag raised when acquisition ends
// - Hold bit cleared: re-clear, then acquire
package stats_seq_pkg;
  localparam int DATA_W = 24;
  localparam int SIZE_W = 13;
  localparam int ADDR_W = 12;
  localparam int ERR_W = 32;
  localparam int ERR_LINE_SHORT = 0;
  localparam int ERR_LINE_LONG = 1;
  localparam int ERR_FRAME_EARLY = 2;
  localparam int ERR_FRAME_LATE = 3;
  localparam logic [1:0] PREC_8 = 2'h0;
  localparam logic [1:0] PREC_10 = 2'h1;
  localparam logic [1:0] PREC_12 = 2'h2;
  localparam logic [ADDR_W-1:0] LAST_ADDR_8 = 12'h0FF;
  localparam logic [ADDR_W-1:0] LAST_ADDR_10 = 12'h3FF;
  localparam logic [ADDR_W-1:0] LAST_ADDR_12 = 12'hFFF;
  localparam logic [1:0] WARM_LINES = 2'h2;
  localparam logic [ERR_W-1:0] ERR_RESET = 32'h0;

  typedef enum logic [1:0] {
    ST_CLEAR = 2'b00,
    ST_WAIT_SOF = 2'b01,
    ST_ACQUIRE = 2'b10,
    ST_READOUT = 2'b11
  } seq_state_e;

  typedef struct packed {
    logic [DATA_W-1:0] tdata;
    logic tuser;
    logic tlast;
    logic tvalid;
  } video_beat_s;

  typedef struct packed {
    logic [SIZE_W-1:0] active_width;
    logic [SIZE_W-1:0] active_height;
    logic [1:0] precision;
    logic hold_readout;
  } seq_cfg_s;

  typedef struct packed {
    seq_state_e state;
    logic done;
    logic readout_active;
  } seq_status_s;
endpackage

// file: rtl/stats_frame_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module stats_frame_sequencer (
  input wire logic clk,
  input wire logic ce,
  input wire logic rstn,
  input wire stats_seq_pkg::seq_cfg_s cfg,
  input wire logic [3:0] err_clear,
  input wire logic done_clear,
  input wire stats_seq_pkg::video_beat_s s_beat,
  output logic s_tready,
  output stats_seq_pkg::video_beat_s m_beat,
  input wire logic m_tready,
  output logic [stats_seq_pkg::ERR_W-1:0] stream_error_flags,
  output stats_seq_pkg::seq_status_s status,
  output logic clr_we,
  output logic [stats_seq_pkg::ADDR_W-1:0] clr_addr,
  output logic meas_en,
  output logic acq_done
);
  import stats_seq_pkg::*;

  ////////////////////////////////////////////////////////////////////
  // Decoding helpers

  function automatic logic [ADDR_W-1:0] last_addr(
    input logic [1:0] prec
  );
    logic [ADDR_W-1:0] a;
    a = LAST_ADDR_12;
    if (prec == PREC_8) begin
      a = LAST_ADDR_8;
    end else if (prec == PREC_10) begin
      a = LAST_ADDR_10;
    end
    return a;
  endfunction

  ////////////////////////////////////////////////////////////////////
  // State and counters

  seq_state_e state_q;
  seq_state_e state_d;
  logic [ADDR_W-1:0] addr_q;
  logic [ADDR_W-1:0] addr_d;
  logic [SIZE_W-1:0] pix_q;
  logic [SIZE_W-1:0] pix_d;
  logic [SIZE_W-1:0] line_q;
  logic [SIZE_W-1:0] line_d;
  logic [SIZE_W-1:0] acq_line_q;
  logic [SIZE_W-1:0] acq_line_d;
  logic [1:0] warm_q;
  logic [1:0] warm_d;
  logic started_q;
  logic seen_sof_q;
  logic sof_prev_q;
  logic done_q;
  logic acq_done_q;
  logic [3:0] err_q;
  logic [3:0] err_set;
  video_beat_s out_q;

  ////////////////////////////////////////////////////////////////////
  // Stream decode

  wire run = ce && (state_q != ST_CLEAR);
  wire out_free = !out_q.tvalid || m_tready;
  wire beat = s_beat.tvalid && s_tready;
  wire sof_beat = beat && s_beat.tuser;
  wire eol_beat = beat && s_beat.tlast;
  wire excess = (pix_q >= cfg.active_width);
  wire warm_done = (warm_q == WARM_LINES);
  wire fwd = beat && warm_done && !excess;
  wire sof_rise = sof_beat && !sof_prev_q;
  wire clear_last = (addr_q == last_addr(cfg.precision));
  wire acq_end = (state_q == ST_ACQUIRE) && eol_beat
    && (acq_line_q + 13'h1 >= cfg.active_height);

  // Clearing blocks input; stall lets the output stage fill first
  assign s_tready = run && out_free;

  ////////////////////////////////////////////////////////////////////
  // Error detection

  always_comb begin
    err_set = 4'h0;
    // The end beat itself is a pixel, hence the plus one
    if (eol_beat && (pix_q + 13'h1 < cfg.active_width)) begin
      err_set[ERR_LINE_SHORT] = 1'b1;
    end
    if (beat && excess) begin
      err_set[ERR_LINE_LONG] = 1'b1;
    end
    if (sof_beat && seen_sof_q) begin
      if (line_q < cfg.active_height) begin
        err_set[ERR_FRAME_EARLY] = 1'b1;
      end
      if (line_q > cfg.active_height) begin
        err_set[ERR_FRAME_LATE] = 1'b1;
      end
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_err
      // Set beats clear so no fault is lost in the clear cycle
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          err_q[gi] <= 1'b0;
        end else if (err_set[gi]) begin
          err_q[gi] <= 1'b1;
        end else if (err_clear[gi]) begin
          err_q[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  assign stream_error_flags = {{(ERR_W-4){1'b0}}, err_q} | ERR_RESET;

  ////////////////////////////////////////////////////////////////////
  // Line and frame counters

  always_comb begin
    pix_d = pix_q;
    line_d = line_q;
    if (beat) begin
      if (s_beat.tlast) begin
        pix_d = '0;
      end else if (!excess) begin
        pix_d = pix_q + 13'h1;
      end
    end
    if (sof_beat) begin
      line_d = s_beat.tlast ? 13'h1 : 13'h0;
    end else if (eol_beat) begin
      line_d = line_q + 13'h1;
    end
  end

  // Output held off for two lines after the first clear finishes
  always_comb begin
    warm_d = warm_q;
    if (started_q && eol_beat && !warm_done) begin
      warm_d = warm_q + 2'h1;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pix_q <= '0;
      line_q <= '0;
      warm_q <= '0;
      seen_sof_q <= 1'b0;
      sof_prev_q <= 1'b0;
    end else if (ce) begin
      pix_q <= pix_d;
      line_q <= line_d;
      warm_q <= warm_d;
      if (sof_beat) begin
        seen_sof_q <= 1'b1;
      end
      if (beat) begin
        sof_prev_q <= s_beat.tuser;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Output stage

  // Excess pixels are taken and dropped so the line can drain
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      out_q <= '0;
    end else if (ce) begin
      if (fwd) begin
        out_q <= s_beat;
        out_q.tvalid <= 1'b1;
      end else if (m_tready) begin
        out_q.tvalid <= 1'b0;
      end
    end
  end

  assign m_beat = out_q;

  ////////////////////////////////////////////////////////////////////
  // Processing sequence

  always_comb begin
    state_d = state_q;
    addr_d = addr_q;
    acq_line_d = acq_line_q;
    unique case (state_q)
      ST_CLEAR: begin
        addr_d = addr_q + 12'h1;
        if (clear_last) begin
          addr_d = '0;
          state_d = ST_WAIT_SOF;
        end
      end
      ST_WAIT_SOF: begin
        acq_line_d = '0;
        if (sof_rise) begin
          state_d = ST_ACQUIRE;
          acq_line_d = s_beat.tlast ? 13'h1 : 13'h0;
        end
      end
      ST_ACQUIRE: begin
        if (eol_beat) begin
          acq_line_d = acq_line_q + 13'h1;
        end
        if (acq_end) begin
          state_d = cfg.hold_readout ? ST_READOUT : ST_CLEAR;
        end
      end
      ST_READOUT: begin
        if (!cfg.hold_readout) begin
          state_d = ST_CLEAR;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= ST_CLEAR;
      addr_q <= '0;
      acq_line_q <= '0;
    end else if (ce) begin
      state_q <= state_d;
      addr_q <= addr_d;
      acq_line_q <= acq_line_d;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      started_q <= 1'b0;
    end else if (ce && (state_q == ST_CLEAR) && clear_last) begin
      started_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Done flag and strobes

  // Set wins against a clear arriving in the same cycle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      done_q <= 1'b0;
      acq_done_q <= 1'b0;
    end else begin
      acq_done_q <= ce && acq_end;
      if (ce && acq_end) begin
        done_q <= 1'b1;
      end else if (done_clear) begin
        done_q <= 1'b0;
      end
    end
  end

  assign acq_done = acq_done_q;
  assign clr_we = ce && (state_q == ST_CLEAR);
  assign clr_addr = addr_q;
  // Readout state blocks updates of the single-buffered data
  assign meas_en = beat && !excess
    && ((state_q == ST_ACQUIRE) || ((state_q == ST_WAIT_SOF) && sof_rise));
  assign status.state = state_q;
  assign status.done = done_q;
  assign status.readout_active = (state_q == ST_READOUT);
endmodule // stats_frame_sequencer
`default_nettype wire

// file: verif/stats_seq_checker.sv
`timescale 1ns/1ps
`default_nettype none
module stats_seq_checker (
  input wire logic clk,
  input wire logic ce,
  input wire logic rstn,
  input wire stats_seq_pkg::seq_cfg_s cfg,
  input wire logic [3:0] err_clear,
  input wire stats_seq_pkg::video_beat_s s_beat,
  input wire logic s_tready,
  input wire stats_seq_pkg::video_beat_s m_beat,
  input wire logic m_tready,
  input wire logic [stats_seq_pkg::ERR_W-1:0] stream_error_flags,
  input wire stats_seq_pkg::seq_status_s status,
  input wire logic clr_we,
  input wire logic [stats_seq_pkg::ADDR_W-1:0] clr_addr,
  input wire logic acq_done
);
  import stats_seq_pkg::*;
  logic [ADDR_W-1:0] last_w;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  assign last_w = cfg.precision == PREC_8 ? LAST_ADDR_8 : cfg.precision == PREC_10 ? LAST_ADDR_10 : LAST_ADDR_12;
  chk_ready_clear: assert property (status.state == ST_CLEAR |-> !s_tready)
    else $error("ready while clearing");
  chk_clear_step: assert property (clr_we && clr_addr != last_w |=> clr_addr == $past(clr_addr) + 12'h1)
    else $error("clear address skipped");
  chk_clear_exit: assert property (clr_we && clr_addr == last_w |=> status.state == ST_WAIT_SOF)
    else $error("clear end missed");
  chk_wait_hold: assert property (status.state == ST_WAIT_SOF && !(s_beat.tvalid && s_tready && s_beat.tuser)
    |=> status.state != ST_ACQUIRE)
    else $error("acquire without frame start");
  chk_out_hold: assert property (m_beat.tvalid && !m_tready |=> $stable(m_beat))
    else $error("output dropped in stall");
  chk_full_block: assert property (m_beat.tvalid && !m_tready |-> !s_tready)
    else $error("input taken while full");
  chk_done_cause: assert property (acq_done |-> $past(status.state) == ST_ACQUIRE)
    else $error("done pulse outside acquire");
  chk_readout_leave: assert property (status.state == ST_READOUT && !cfg.hold_readout && ce
    |=> status.state == ST_CLEAR)
    else $error("readout not left");
  chk_err_sticky: assert property ((($past(stream_error_flags[3:0]) & ~$past(err_clear))
    & ~stream_error_flags[3:0]) == 4'h0)
    else $error("error flag lost");
endmodule // stats_seq_checker
`default_nettype wire

// file: verif/video_sink.sv
`timescale 1ns/1ps
`default_nettype none
module video_sink (
  input wire logic clk,
  input wire logic rstn,
  input wire stats_seq_pkg::video_beat_s m_beat,
  input wire logic [3:0] slow,
  output logic m_tready,
  output logic [15:0] beats
);
  import stats_seq_pkg::*;
  logic [3:0] wait_q;
  // Stalls each beat so backpressure reaches the input side
  assign m_tready = wait_q >= slow;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wait_q <= 4'h0;
      beats <= 16'h0;
    end else if (m_beat.tvalid && m_tready) begin
      wait_q <= 4'h0;
      beats <= beats + 16'h1;
    end else if (m_beat.tvalid) begin
      wait_q <= wait_q + 4'h1;
    end
  end
endmodule // video_sink
`default_nettype wire

// file: verif/stats_frame_sequencer_tb.sv
`timescale 1ns/1ps
`default_nettype none
module stats_frame_sequencer_tb;
  import stats_seq_pkg::*;
  logic clk, ce, rstn, done_clear, s_tready, m_tready, clr_we, meas_en, acq_done;
  logic [3:0] err_clear, slow;
  logic [15:0] beats;
  logic [ERR_W-1:0] flags;
  logic [ADDR_W-1:0] clr_addr;
  seq_cfg_s cfg;
  video_beat_s s_beat, m_beat;
  seq_status_s status;
  int err_total, check_count, blocked, meas_cnt, n;
  stats_frame_sequencer u_stats_frame_sequencer (.clk(clk), .ce(ce), .rstn(rstn), .cfg(cfg),
    .err_clear(err_clear), .done_clear(done_clear), .s_beat(s_beat), .s_tready(s_tready), .m_beat(m_beat),
    .m_tready(m_tready), .stream_error_flags(flags), .status(status), .clr_we(clr_we), .clr_addr(clr_addr),
    .meas_en(meas_en), .acq_done(acq_done));
  video_sink u_video_sink (.clk(clk), .rstn(rstn), .m_beat(m_beat), .slow(slow), .m_tready(m_tready),
    .beats(beats));
  ////////////////////////////////////////////////////////////////
  task automatic complete_run;
    if (err_total == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  // Counts edges until input ready; also the cut for a hang
  task automatic wait_ready(output int c);
    c = 0;
    repeat (5000) begin
      @(negedge clk);
      if (s_tready) break;
      c++;
    end
    if (!s_tready) begin
      check(c, 0);
      complete_run;
    end
    @(posedge clk);
  endtask
  task automatic send(input int len, input logic sof);
    for (int i = 0; i < len; i++) begin
      s_beat <= '{i[23:0], sof && i == 0, i == len - 1, 1'b1};
      wait_ready(n);
    end
    // Valid stays up so back-to-back sends never drive it twice in one step
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    clk = 0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (m_beat.tvalid && !m_tready && s_beat.tvalid && !s_tready) blocked++;
    if (meas_en) meas_cnt++;
  end
  initial begin
    ce = 0;
    rstn = 0;
    done_clear = 0;
    err_clear = 4'h0;
    slow = 4'h0;
    s_beat = '0;
    cfg = '{13'h4, 13'h2, PREC_8, 1'b1};
    err_total = 0;
    check_count = 0;
    blocked = 0;
    meas_cnt = 0;
    repeat (5) @(posedge clk);
    rstn <= 1;
    // Clear must not advance while enable is low
    repeat (10) @(posedge clk);
    ce <= 1;
    wait_ready(n);
    check(n, 256);
    send(4, 0);
    send(4, 0);
    s_beat.tvalid <= 1'b0;
    repeat (4) @(posedge clk);
    check(beats, 0);
    slow <= 4'h3;
    send(4, 1);
    send(6, 0);
    s_beat.tvalid <= 1'b0;
    repeat (8) @(posedge clk);
    check(beats, 8);
    check(meas_cnt, 8);
    check(flags, 32'h2);
    check(status, {ST_READOUT, 2'b11});
    check(blocked > 0, 1);
    err_clear <= 4'hF;
    done_clear <= 1;
    @(posedge clk);
    err_clear <= 4'h0;
    done_clear <= 0;
    slow <= 4'h0;
    cfg.hold_readout <= 0;
    // Readout still takes input, so count only once clearing has begun
    @(posedge clk);
    wait_ready(n);
    check(n, 256);
    check(flags, 32'h0);
    check(status, {ST_WAIT_SOF, 2'b00});
    send(3, 0);
    send(4, 1);
    send(4, 1);
    s_beat.tvalid <= 1'b0;
    repeat (3) @(posedge clk);
    check(flags, 32'hD);
    check(meas_cnt, 16);
    check(status.state, ST_CLEAR);
    complete_run;
  end
endmodule // stats_frame_sequencer_tb
bind stats_frame_sequencer stats_seq_checker u_stats_seq_checker (.*);
`default_nettype wire
